/* core/tpq_top.sv */
// Transmit packet queue with manual release of packet memory.
// Assumes host command strobes and MAC signals are on REF_CLK.
`include "tpq_map.svh"

module tpq_top
  import tpq_pkg::*;
(
  input  wire logic                    REF_CLK,        // 50 MHz core clock
  input  wire logic                    NRST,           // Async reset, active low
  input  wire logic                    ALLOC_REQ,      // Allocate command pulse
  input  wire logic [`TPQ_LEN_W-1:0]   ALLOC_BYTES,    // Requested byte count
  input  wire logic                    ALLOC_DONE_CLR, // Clears alloc_done_flag
  output logic                         ALLOC_DONE,     // alloc_done_flag
  output logic                         ALLOC_FAIL,     // Request too large or zero bytes
  output logic [`TPQ_PNUM_W-1:0]       ALLOC_RESULT,   // Allocated number
  input  wire logic                    PNUM_WR,        // Load packet number
  input  wire logic [`TPQ_PNUM_W-1:0]  PNUM_IN,        // Packet number value
  output logic [`TPQ_PNUM_W-1:0]       PNUM,           // Packet number register
  input  wire logic                    PTR_WR,         // Load word pointer
  input  wire logic [`TPQ_WADDR_W-1:0] PTR_IN,         // Word pointer value
  input  wire logic                    DATA_WR,        // Write data word
  input  wire logic [`TPQ_DATA_W-1:0]  DATA_IN,        // Data word in
  output logic                         DATA_WR_READY,  // Data write accepted
  input  wire logic                    DATA_RD,        // Read data word
  output logic [`TPQ_DATA_W-1:0]       DATA_OUT,       // Data word read
  input  wire logic                    ENQUEUE,        // Enqueue command pulse
  output logic                         TXQ_FULL,       // Transmit FIFO full
  input  wire logic                    RELEASE,        // Release command pulse
  input  wire logic                    TX_ACK,         // Interrupt acknowledge
  input  wire logic                    TX_EN_SET,      // Sets tx_enable_bit
  input  wire logic                    TX_EN_CLR,      // Clears tx_enable_bit
  output logic                         TX_ENABLE,      // tx_enable_bit
  input  wire logic                    FULL_DUPLEX,    // Duplex mode
  input  wire logic                    DEFER_OK,       // Deferral permits send
  output logic                         TX_INT,         // Transmit interrupt
  output logic                         FIFO_PORT_VLD,  // Completion head valid
  output logic [`TPQ_PNUM_W-1:0]       FIFO_PORT,      // Completion head number
  output logic                         MAC_VALID,      // Frame word valid
  input  wire logic                    MAC_READY,      // MAC takes word
  output logic [`TPQ_DATA_W-1:0]       MAC_DATA,       // Frame word
  output logic                         MAC_LAST,       // Last word of frame
  input  wire logic                    MAC_DONE,       // Transmission finished
  input  wire logic                    MAC_OK,         // Finished without error
  input  wire logic [`TPQ_DATA_W-1:0]  MAC_STATUS      // Status word to store
);

  localparam int AW = `TPQ_PNUM_W + `TPQ_WADDR_W;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [`TPQ_DATA_W-1:0] pmem [2**AW];
  tpq_len_t               plen [`TPQ_NPKT];
  logic [`TPQ_NPKT-1:0]   free_map;
  logic                   alloc_pend;
  tpq_len_t               alloc_len;
  logic                   alloc_done;
  logic                   alloc_fail;
  tpq_pnum_t              alloc_res;
  tpq_pnum_t              pnr;
  tpq_waddr_t             ptr;
  logic [`TPQ_DATA_W-1:0] data_out;
  logic                   tx_en;
  tpq_state_t             state;
  tpq_pnum_t              cur_pkt;
  tpq_waddr_t             word_idx;
  tpq_waddr_t             last_idx;
  logic [`TPQ_DATA_W-1:0] status_q;
  logic                   status_ok;

  tpq_stream_if #(.WIDTH(`TPQ_PNUM_W))     txq ();
  tpq_stream_if #(.WIDTH(`TPQ_PNUM_W))     cmpq ();
  tpq_stream_if #(.WIDTH(`TPQ_DATA_W + 1)) obuf ();

  tpq_fifo #(.WIDTH(`TPQ_PNUM_W), .DEPTH(`TPQ_QDEPTH)) u_txq (
    .clk   (REF_CLK),
    .rst_n (NRST),
    .s     (txq)
  );
  tpq_fifo #(.WIDTH(`TPQ_PNUM_W), .DEPTH(`TPQ_QDEPTH)) u_cmpq (
    .clk   (REF_CLK),
    .rst_n (NRST),
    .s     (cmpq)
  );
  // Two-entry skid so a MAC stall loses no frame word
  tpq_fifo #(.WIDTH(`TPQ_DATA_W + 1), .DEPTH(`TPQ_BUFDEPTH)) u_obuf (
    .clk   (REF_CLK),
    .rst_n (NRST),
    .s     (obuf)
  );

  // ------------------------------------------------------------
  // Allocation decode
  // ------------------------------------------------------------
  // Lowest free packet number; priority order keeps allocation repeatable
  function automatic tpq_pnum_t first_free(input logic [`TPQ_NPKT-1:0] m);
    tpq_pnum_t r;
    r = '0;
    for (int i = `TPQ_NPKT - 1; i >= 0; i--) begin
      if (m[i]) r = tpq_pnum_t'(i);
    end
    return first_free_r(r);
  endfunction
  function automatic tpq_pnum_t first_free_r(input tpq_pnum_t r);
    return r;
  endfunction

  wire       any_free   = |free_map;
  wire       too_big    = (ALLOC_BYTES > `TPQ_MAX_BYTES) || (ALLOC_BYTES == '0);
  wire       new_req    = ALLOC_REQ & ~too_big;
  wire       grant      = alloc_pend & any_free;
  wire       tx_release = RELEASE;
  tpq_pnum_t grant_num;
  assign grant_num = first_free(free_map);

  // Pending request waits for a free packet; an oversize one fails [RULE1]
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      alloc_pend <= 1'b0;
      alloc_len  <= '0;
      alloc_fail <= 1'b0;
    end else begin
      if (new_req) begin
        alloc_pend <= 1'b1;
        alloc_len  <= ALLOC_BYTES;
      end else if (grant) begin
        alloc_pend <= 1'b0;
      end
      if (ALLOC_REQ) alloc_fail <= too_big;
    end
  end

  // Done flag: a grant in the clearing cycle still sets it [RULE2]
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      alloc_done <= 1'b0;
      alloc_res  <= '0;
    end else begin
      if (grant) begin
        alloc_done <= 1'b1;
        alloc_res  <= grant_num;
      end else if (ALLOC_DONE_CLR || ALLOC_REQ) begin
        alloc_done <= 1'b0;
      end
    end
  end

  // Free pool: grant takes, release returns; completion never frees [RULE13] [RULE16]
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      free_map <= `TPQ_FREE_RST;
    end else begin
      for (int i = 0; i < `TPQ_NPKT; i++) begin
        if (grant && grant_num == tpq_pnum_t'(i)) free_map[i] <= 1'b0;
        else if (tx_release && pnr == tpq_pnum_t'(i)) free_map[i] <= 1'b1;
      end
    end
  end

  // Length kept per packet for the sender
  always_ff @(posedge REF_CLK) begin
    if (grant) plen[grant_num] <= alloc_len;
  end

  // ------------------------------------------------------------
  // Host data path
  // ------------------------------------------------------------
  wire          status_wr = (state == TPQ_DONE);
  wire          host_wr   = DATA_WR & ~status_wr;
  wire [AW-1:0] host_addr = {pnr, ptr};
  wire [AW-1:0] stat_addr = {cur_pkt, `TPQ_WADDR_W'(0)};
  wire [AW-1:0] send_addr = {cur_pkt, word_idx};

  // Status write owns the port for one cycle; host write waits [RULE7]
  always_ff @(posedge REF_CLK) begin
    if (status_wr) pmem[stat_addr] <= status_q;
    else if (host_wr) pmem[host_addr] <= DATA_IN;  // [RULE4]
  end

  // Packet number, pointer and read port; status read via word 0 [RULE12]
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      pnr      <= '0;
      ptr      <= '0;
      data_out <= '0;
    end else begin
      if (PNUM_WR) pnr <= PNUM_IN;
      if (PTR_WR) ptr <= PTR_IN;
      else if (host_wr || DATA_RD) ptr <= ptr + 1'b1;
      if (DATA_RD) data_out <= pmem[host_addr];
    end
  end

  // ------------------------------------------------------------
  // Queues
  // ------------------------------------------------------------
  // Enqueue pushes the packet number register; refused while full [RULE5]
  assign txq.in_valid  = ENQUEUE;
  assign txq.in_data   = pnr;
  // Completion moves the head number across; acknowledge pops [RULE8] [RULE14]
  assign txq.out_ready = status_wr;
  assign cmpq.in_valid = status_wr;
  assign cmpq.in_data  = cur_pkt;
  assign cmpq.out_ready = TX_ACK;

  // Send may start only with enable and, in half duplex, deferral [RULE6]
  wire start_ok = txq.out_valid & tx_en & (FULL_DUPLEX | DEFER_OK);
  wire word_go  = (state == TPQ_SEND) & obuf.in_ready;
  wire is_last  = (word_idx == last_idx);

  assign obuf.in_valid  = (state == TPQ_SEND);
  assign obuf.in_data   = {is_last, pmem[send_addr]};
  assign obuf.out_ready = MAC_READY;

  // ------------------------------------------------------------
  // Transmit sequencer
  // ------------------------------------------------------------
  tpq_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      TPQ_IDLE: if (start_ok) next_state = TPQ_SEND;
      TPQ_SEND: if (word_go && is_last) next_state = TPQ_WAIT;
      TPQ_WAIT: if (MAC_DONE) next_state = TPQ_DONE;
      TPQ_DONE: next_state = TPQ_IDLE;
    endcase
  end

  // Words needed = ceiling of bytes over four, less one
  wire [`TPQ_LEN_W-1:0] len_m1 = plen[txq.out_data] - 1'b1;

  // Sequencer registers: packet, word index and captured status
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      state     <= TPQ_IDLE;
      cur_pkt   <= '0;
      word_idx  <= '0;
      last_idx  <= '0;
      status_q  <= '0;
      status_ok <= 1'b1;
    end else begin
      state <= next_state;
      if (state == TPQ_IDLE && start_ok) begin
        cur_pkt  <= txq.out_data;
        word_idx <= '0;
        last_idx <= len_m1[`TPQ_WADDR_W+1:2];
      end
      if (word_go) word_idx <= word_idx + 1'b1;
      if (state == TPQ_WAIT && MAC_DONE) begin
        status_q  <= MAC_STATUS;
        status_ok <= MAC_OK;
      end
    end
  end

  // Failure drops the enable so the queue halts after this packet [RULE10]
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_en <= `TPQ_TXEN_RST;
    end else if (status_wr && !status_ok) begin
      tx_en <= 1'b0;
    end else if (TX_EN_SET) begin
      tx_en <= 1'b1;  // Host restarts after failure [RULE15]
    end else if (TX_EN_CLR) begin
      tx_en <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Interrupt while any number waits, failed ones included [RULE9] [RULE10]
  assign TX_INT        = cmpq.out_valid;
  assign FIFO_PORT_VLD = cmpq.out_valid;
  assign FIFO_PORT     = cmpq.out_data;  // Host reads it here [RULE11]
  assign ALLOC_DONE    = alloc_done;
  assign ALLOC_FAIL    = alloc_fail;
  assign ALLOC_RESULT  = alloc_res;
  assign PNUM          = pnr;
  assign DATA_OUT      = data_out;
  assign DATA_WR_READY = ~status_wr;
  assign TXQ_FULL      = ~txq.in_ready;
  assign TX_ENABLE     = tx_en;
  assign MAC_VALID     = obuf.out_valid;
  assign MAC_DATA      = obuf.out_data[`TPQ_DATA_W-1:0];
  assign MAC_LAST      = obuf.out_data[`TPQ_DATA_W];

endmodule // tpq_top

/* core/tpq_map.svh */
// Constants of the transmit packet queue: sizes, reset values, widths.
// Assumes inclusion by the package and the modules of this block only.
//
// Contract
// RULE1: Allocate command tries to reserve the requested bytes for one packet.
// RULE2: Successful allocation sets done flag and shows the new packet number.
// RULE3: Host waits for allocation by polling the done flag or its interrupt; this block has no allocation interrupt.
// RULE4: Host loads packet number, pointer, then writes frame data words.
// RULE5: Enqueue pushes the current packet number into the transmit FIFO.
// RULE6: Packet goes to MAC only with transmit enable, and deferral in half duplex.
// RULE7: On finish, status word overwrites the first word of the packet buffer.
// RULE8: On finish, packet number moves from transmit FIFO to completion FIFO.
// RULE9: Transmit interrupt stands while the completion FIFO is not empty.
// RULE10: Failure raises interrupt, clears enable, halts, shows failed number.
// RULE11: Host reads completed number from FIFO port, writes packet number.
// RULE12: Loaded completed packet's status word is readable by data reads.
// RULE13: Release command on a packet returns its memory to the free pool.
// RULE14: Acknowledge write removes the head number from the completion FIFO.
// RULE15: After failure host releases, or reloads, re-enables and re-enqueues.
// RULE16: Without auto release, sent packet memory stays allocated until released.
// RULE17: Both FIFOs return packet numbers in first-in, first-out order.
`ifndef TPQ_MAP_SVH
`define TPQ_MAP_SVH

// ------------------------------------------------------------
// Packet memory geometry
// ------------------------------------------------------------
`define TPQ_NPKT      4
`define TPQ_PNUM_W    2
`define TPQ_WADDR_W   9
`define TPQ_LEN_W     12
`define TPQ_MAX_BYTES 12'h800
`define TPQ_DATA_W    32

// ------------------------------------------------------------
// Queue depths and reset values
// ------------------------------------------------------------
`define TPQ_QDEPTH    4
`define TPQ_BUFDEPTH  2
`define TPQ_TXEN_RST  1'b0
`define TPQ_FREE_RST  4'hF

`endif

/* core/tpq_pkg.sv */
// Types shared by the transmit packet queue modules.
// Assumes tpq_map.svh is on the include path.
`include "tpq_map.svh"

package tpq_pkg;

  // Transmit sequencer states, Gray along idle-send-wait-done
  typedef enum logic [1:0] {
    TPQ_IDLE = 2'b00,
    TPQ_SEND = 2'b01,
    TPQ_WAIT = 2'b11,
    TPQ_DONE = 2'b10
  } tpq_state_t;

  typedef logic [`TPQ_PNUM_W-1:0]  tpq_pnum_t;
  typedef logic [`TPQ_WADDR_W-1:0] tpq_waddr_t;
  typedef logic [`TPQ_LEN_W-1:0]   tpq_len_t;

endpackage

/* core/tpq_stream_if.sv */
// Valid/ready stream carrier between the queue core and its FIFOs.
// Assumes both ends share one clock.
interface tpq_stream_if #(parameter int WIDTH = 8);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface

/* core/tpq_fifo.sv */
// First-in first-out store with valid/ready on both sides.
// Assumes DEPTH is a power of two and a single clock.
module tpq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,    // Core clock
  input wire logic rst_n,  // Asynchronous reset, active low
  tpq_stream_if.fifo s     // Fill and drain sides
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  // ------------------------------------------------------------
  // Handshake decode
  // ------------------------------------------------------------
  wire push = s.in_valid & s.in_ready;
  wire pop  = s.out_valid & s.out_ready;

  assign s.in_ready  = (count != (AW + 1)'(DEPTH));
  assign s.out_valid = (count != '0);
  assign s.out_data  = mem[rd_ptr];  // Head word straight from storage [RULE17]

  // Storage, written only at the tail
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= s.in_data;
    end
  end

  // Pointers advance in order, so words leave as they came [RULE17]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule // tpq_fifo

/* testbench/tpq_monitor.sv */
// Port-level assertions for the transmit packet queue top.
// Assumes binding onto tpq_top; all checks run on REF_CLK.
`include "tpq_map.svh"

module tpq_monitor (
  input wire logic                  REF_CLK,        // Core clock
  input wire logic                  NRST,           // Reset, active low
  input wire logic                  ALLOC_REQ,      // Allocate pulse
  input wire logic [`TPQ_LEN_W-1:0] ALLOC_BYTES,    // Requested bytes
  input wire logic                  ALLOC_DONE_CLR, // Done clear
  input wire logic                  ALLOC_DONE,     // Done flag
  input wire logic                  ALLOC_FAIL,     // Refused request
  input wire logic [`TPQ_PNUM_W-1:0] ALLOC_RESULT,  // Granted number
  input wire logic                  DATA_WR_READY,  // Host write slot
  input wire logic                  TX_ENABLE,      // Transmit enable
  input wire logic                  FULL_DUPLEX,    // Duplex mode
  input wire logic                  DEFER_OK,       // Deferral permit
  input wire logic                  TX_ACK,         // Acknowledge pulse
  input wire logic                  TX_INT,         // Transmit interrupt
  input wire logic                  FIFO_PORT_VLD,  // Head valid
  input wire logic [`TPQ_PNUM_W-1:0] FIFO_PORT,     // Head number
  input wire logic                  MAC_VALID,      // Word valid
  input wire logic                  MAC_READY,      // Word taken
  input wire logic [`TPQ_DATA_W-1:0] MAC_DATA,      // Frame word
  input wire logic                  MAC_LAST,       // Last word
  input wire logic                  MAC_DONE,       // Frame finished
  input wire logic                  MAC_OK          // Finished well
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // Launch window; four samples cover the idle-to-send walk
  wire launch_ok = TX_ENABLE && (FULL_DUPLEX || DEFER_OK);

  a_alloc_refused: assert property (ALLOC_REQ && (ALLOC_BYTES == 12'h000 ||
    ALLOC_BYTES > `TPQ_MAX_BYTES) |-> ##[1:2] (ALLOC_FAIL && !ALLOC_DONE))
    else $error("refused allocation not flagged");
  a_grant_holds: assert property (ALLOC_DONE && !ALLOC_DONE_CLR && !ALLOC_REQ
    |=> ALLOC_DONE && $stable(ALLOC_RESULT)) else $error("grant lost");
  a_int_mirror: assert property (TX_INT == FIFO_PORT_VLD)
    else $error("interrupt differs from head valid");
  a_int_source: assert property ($rose(TX_INT) |-> $past(MAC_DONE, 2))
    else $error("interrupt rose without a completion");
  a_head_holds: assert property (TX_INT && !TX_ACK |=> TX_INT && $stable(FIFO_PORT))
    else $error("completion head moved without acknowledge");
  a_done_raises: assert property (MAC_DONE |-> ##[1:3] TX_INT)
    else $error("completion did not raise interrupt");
  a_fail_disables: assert property (MAC_DONE && !MAC_OK |-> ##[1:2] !TX_ENABLE)
    else $error("failure left transmit enabled");
  a_status_slot: assert property ($fell(DATA_WR_READY) |->
    ($past(MAC_DONE) || $past(MAC_DONE, 2)) ##1 DATA_WR_READY)
    else $error("status write slot misplaced");
  a_launch_gate: assert property ($rose(MAC_VALID) |-> ($past(launch_ok) ||
    $past(launch_ok, 2) || $past(launch_ok, 3) || $past(launch_ok, 4)))
    else $error("frame sent without permission");
  a_stream_hold: assert property (MAC_VALID && !MAC_READY |=> MAC_VALID &&
    $stable(MAC_DATA) && $stable(MAC_LAST)) else $error("stalled word changed");
endmodule // tpq_monitor

bind tpq_top tpq_monitor i_tpq_monitor (.REF_CLK, .NRST, .ALLOC_REQ, .ALLOC_BYTES,
  .ALLOC_DONE_CLR, .ALLOC_DONE, .ALLOC_FAIL, .ALLOC_RESULT, .DATA_WR_READY, .TX_ENABLE,
  .FULL_DUPLEX, .DEFER_OK, .TX_ACK, .TX_INT, .FIFO_PORT_VLD, .FIFO_PORT, .MAC_VALID,
  .MAC_READY, .MAC_DATA, .MAC_LAST, .MAC_DONE, .MAC_OK);

/* testbench/tpq_mac_model.sv */
// Stand-in MAC: takes frame words and reports each frame's end.
// Assumes the queue's clock; stall and fail are driven by the bench.
module tpq_mac_model (
  input  wire logic        clk,    // Core clock
  input  wire logic        rst_n,  // Reset, active low
  input  wire logic        valid,  // Word valid
  input  wire logic [31:0] data,   // Frame word
  input  wire logic        last,   // Last word
  input  wire logic        stall,  // Take words every other cycle
  input  wire logic        fail,   // Report frames as failed
  output logic             ready,  // Word taken
  output logic             done,   // Frame finished
  output logic             ok,     // Finished well
  output logic [31:0]      status  // Status word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        phase;
  logic        ok_q;
  logic [1:0]  gap;
  logic [31:0] st_q;
  logic [31:0] rx [0:31];
  int unsigned count;
  int unsigned frames;
  // Gapped ready forces the queue's buffer to hold words
  assign ready = !stall || phase;
  // Off the pulse the answer shows the inverse, so stale values never match
  assign ok = done ? ok_q : !ok_q;
  assign status = done ? st_q : ~st_q;
  // Collect words, report two edges after the last one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      done <= 1'b0;
      gap <= 2'h0;
      count <= 0;
      frames <= 0;
      ok_q <= 1'b1;
      st_q <= 32'h0000_0000;
    end else begin
      phase <= ~phase;
      done <= 1'b0;
      if (valid && ready) begin
        rx[count[4:0]] <= data;
        count <= count + 1;
        if (last) gap <= 2'h2;
      end
      if (gap != 2'h0) gap <= gap - 2'h1;
      if (gap == 2'h1) begin
        done <= 1'b1;
        ok_q <= !fail;
        st_q <= (fail ? 32'hE7E7_0000 : 32'h5A5A_0000) + frames;
        frames <= frames + 1;
      end
    end
  end
endmodule // tpq_mac_model

/* testbench/tb.sv */
// Self-checking bench for the transmit packet queue top.
// Assumes tpq_top, tpq_mac_model and the bound monitor are compiled.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ENQ = 0, REL = 1, ACK = 2, SET = 3, CLR = 4, DCLR = 5, PWR = 6, TWR = 7;
  logic        REF_CLK = 1'b0, NRST = 1'b0;
  logic [7:0]  cmd = 8'h00;
  logic        alloc_req = 1'b0, data_wr = 1'b0, data_rd = 1'b0, stall = 1'b0, fail = 1'b0;
  logic        full_duplex = 1'b1, defer_ok = 1'b0;
  logic [11:0] alloc_bytes = 12'h000;
  logic [1:0]  pnum_in = 2'h0, alloc_result, pnum, fifo_port;
  logic [8:0]  ptr_in = 9'h000;
  logic [31:0] data_in = 32'h0, data_out, mac_data, mac_status, w;
  logic        alloc_done, alloc_fail, wr_ready, tx_enable, tx_int, port_vld, txq_full;
  logic        mac_valid, mac_ready, mac_last, mac_done, mac_ok;
  int          mismatches = 0, samples_checked = 0;
  int          lens [4] = '{8, 5, 4, 4};
  // ------------------------------------------------------------
  // Clock, design and far-side model
  // ------------------------------------------------------------
  always #10 REF_CLK = ~REF_CLK;
  tpq_top i_tpq_top (.REF_CLK, .NRST, .ALLOC_REQ(alloc_req), .ALLOC_BYTES(alloc_bytes),
    .ALLOC_DONE_CLR(cmd[DCLR]), .ALLOC_DONE(alloc_done), .ALLOC_FAIL(alloc_fail),
    .ALLOC_RESULT(alloc_result), .PNUM_WR(cmd[PWR]), .PNUM_IN(pnum_in), .PNUM(pnum),
    .PTR_WR(cmd[TWR]), .PTR_IN(ptr_in), .DATA_WR(data_wr), .DATA_IN(data_in),
    .DATA_WR_READY(wr_ready), .DATA_RD(data_rd), .DATA_OUT(data_out), .ENQUEUE(cmd[ENQ]),
    .TXQ_FULL(txq_full), .RELEASE(cmd[REL]), .TX_ACK(cmd[ACK]), .TX_EN_SET(cmd[SET]),
    .TX_EN_CLR(cmd[CLR]), .TX_ENABLE(tx_enable), .FULL_DUPLEX(full_duplex),
    .DEFER_OK(defer_ok), .TX_INT(tx_int), .FIFO_PORT_VLD(port_vld), .FIFO_PORT(fifo_port),
    .MAC_VALID(mac_valid), .MAC_READY(mac_ready), .MAC_DATA(mac_data), .MAC_LAST(mac_last),
    .MAC_DONE(mac_done), .MAC_OK(mac_ok), .MAC_STATUS(mac_status));
  tpq_mac_model i_tpq_mac_model (.clk(REF_CLK), .rst_n(NRST), .valid(mac_valid),
    .data(mac_data), .last(mac_last), .stall(stall), .fail(fail), .ready(mac_ready),
    .done(mac_done), .ok(mac_ok), .status(mac_status));
  // ------------------------------------------------------------
  // Access tasks; inputs move 1 ns after the edge
  // ------------------------------------------------------------
  task automatic tick;
    @(posedge REF_CLK);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int b);
    cmd[b] = 1'b1;
    tick;
    cmd[b] = 1'b0;
  endtask
  task automatic point(input int p, input int ptr);
    pnum_in = 2'(p);
    pulse(PWR);
    ptr_in = 9'(ptr);
    pulse(TWR);
  endtask
  task automatic alloc(input logic [11:0] b);
    alloc_bytes = b;
    alloc_req = 1'b1;
    tick;
    alloc_req = 1'b0;
    tick;
  endtask
  task automatic wait_alloc;
    for (int i = 0; i < 50 && alloc_done !== 1'b1; i++) tick;
  endtask
  task automatic wait_frames(input int n);
    for (int i = 0; i < 400 && i_tpq_mac_model.frames < n; i++) tick;
    repeat (4) tick;
    check(i_tpq_mac_model.frames, n);
  endtask
  task automatic rd(input int p, input int ptr);
    point(p, ptr);
    data_rd = 1'b1;
    tick;
    data_rd = 1'b0;
    w = data_out;
  endtask
  // Frame word pattern carries packet and word index
  function automatic logic [31:0] word(input int p, input int k);
    return 32'hC0DE_0000 + 32'(p * 16 + k);
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog well beyond the roughly 200 cycles the tests need
  initial begin
    repeat (20000) @(posedge REF_CLK);
    mismatches++;
    tally_and_finish;
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(posedge REF_CLK);
    #1 NRST = 1'b1;
    tick;
    alloc(12'h000);
    check(alloc_fail, 1'b1);
    alloc(12'h801);
    check({alloc_fail, alloc_done}, 2'b10);
    for (int p = 0; p < 4; p++) begin
      alloc(12'(lens[p]));
      wait_alloc;
      check({alloc_done, alloc_result}, {1'b1, 2'(p)});
      pulse(DCLR);
      point(p, 0);
      data_wr = 1'b1;
      for (int k = 0; k < 3; k++) begin
        data_in = word(p, k);
        tick;
      end
      data_wr = 1'b0;
    end
    alloc(12'h004);
    repeat (5) tick;
    check(alloc_done, 1'b0);
    pulse(SET);
    check(tx_enable, 1'b1);
    pulse(CLR);
    check(tx_enable, 1'b0);
    $display("test alloc_load done");
    for (int p = 0; p < 2; p++) begin
      point(p, 0);
      pulse(ENQ);
    end
    repeat (20) tick;
    check(i_tpq_mac_model.count, 0);
    full_duplex = 1'b0;
    stall = 1'b1;
    pulse(SET);
    repeat (20) tick;
    check(i_tpq_mac_model.count, 0);
    defer_ok = 1'b1;
    wait_frames(2);
    check(i_tpq_mac_model.count, 4);
    check(i_tpq_mac_model.rx[3], word(1, 1));
    check({tx_int, fifo_port}, 3'b100);
    rd(0, 0);
    check(w, 32'hA5A5_0000 ^ 32'hFFFF_0000);
    rd(1, 1);
    check(w, word(1, 1));
    check(alloc_done, 1'b0);
    point(0, 0);
    pulse(REL);
    wait_alloc;
    check({alloc_done, alloc_result}, 3'b100);
    pulse(DCLR);
    pulse(ACK);
    tick;
    check({tx_int, fifo_port}, 3'b101);
    pulse(ACK);
    tick;
    check(tx_int, 1'b0);
    $display("test send_service done");
    fail = 1'b1;
    point(2, 0);
    pulse(ENQ);
    wait_frames(3);
    check({tx_enable, tx_int, fifo_port}, 4'b0110);
    point(3, 0);
    check(pnum, 2'h3);
    pulse(ENQ);
    check(txq_full, 1'b0);
    repeat (20) tick;
    check(i_tpq_mac_model.frames, 3);
    fail = 1'b0;
    full_duplex = 1'b1;
    defer_ok = 1'b0;
    stall = 1'b0;
    pulse(SET);
    wait_frames(4);
    pulse(ACK);
    tick;
    check({tx_int, fifo_port}, 3'b111);
    $display("test failure_resume done");
    tally_and_finish;
  end
endmodule // tb
